// >>> rtl/rci_pkg.sv
package rci_pkg;
   // Register offsets (byte addresses over the bus)
   localparam logic [11:0] RCI_OFS_STACK_POINTER_AND_FLAGS = 12'hFFC;
   localparam logic [11:0] RCI_OFS_RESET_CAUSE_CONTROL = 12'hFD0;
   localparam logic [11:0] RCI_OFS_TOS = 12'hFF0;
   localparam logic [11:0] RCI_OFS_PC = 12'hFF4;
   localparam logic [11:0] RCI_OFS_HIGH_ANALOG_SELECT = 12'hFE0;
   localparam logic [11:0] RCI_OFS_KEEP = 12'hFE4;
   localparam logic [11:0] RCI_OFS_IRQ_STAT = 12'hFE8;
   localparam logic [11:0] RCI_OFS_IRQ_MASK = 12'hFEC;
   // Reset-cause register bit positions
   localparam int RCI_B_SOFTWARE_BROWNOUT_ENABLE = 6;
   localparam int RCI_B_RI = 4;
   localparam int RCI_B_TO = 3;
   localparam int RCI_B_PD = 2;
   localparam int RCI_B_POR = 1;
   localparam int RCI_B_BOR = 0;
   // Stack pointer register bit positions
   localparam int RCI_B_STACK_FULL_FLAG = 7;
   localparam int RCI_B_STACK_UNDERFLOW_FLAG = 6;
   localparam int RCI_SP_W = 5;
   // Vectors and widths
   localparam int RCI_PC_W = 21;
   localparam logic [20:0] RCI_PC_RESET = 21'h000000;
   localparam logic [20:0] RCI_VEC_HIGH = 21'h000008;
   localparam logic [20:0] RCI_VEC_LOW = 21'h000018;
   localparam logic [20:0] RCI_PC_STEP = 21'h000002;
   localparam logic [1:0] RCI_BORCFG_SW = 2'h1;
   localparam logic [7:0] RCI_HIGH_ANALOG_SELECT_RST = 8'h00;
   localparam logic [7:0] RCI_ZERO8 = 8'h00;
   localparam int RCI_EVT_N = 8;
   // Event types (one per reset or wake source)
   typedef enum logic [3:0] {
      RCI_EV_NONE, RCI_EV_POR, RCI_EV_RESET_INSN, RCI_EV_BOR,
      RCI_EV_EXTERNAL_CLEAR_PIN, RCI_EV_WDT, RCI_EV_STK_FULL, RCI_EV_STK_UNF,
      RCI_EV_IRQ_WAKE
   } rci_event_e;
   // Power modes of the core
   typedef enum logic [1:0] {
      RCI_PM_FULL, RCI_PM_RUN, RCI_PM_IDLE, RCI_PM_SLEEP
   } rci_pmode_e;
endpackage : rci_pkg

// >>> rtl/rci_reset_init.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module rci_reset_init
(
   input wire logic i_clk,
   input wire logic i_rst,
   // Reset and wake sources, one-cycle pulses
   input wire logic i_por,
   input wire logic i_bor,
   input wire logic i_external_clear_pin,
   input wire logic i_wdt,
   input wire logic i_reset_insn,
   input wire logic i_stk_full,
   input wire logic i_stk_unf,
   input wire logic i_irq_wake,
   input wire logic i_irq_high,
   // Core state
   input wire rci_pkg::rci_pmode_e i_pmode,
   input wire logic [20:0] i_pc,
   input wire logic i_global_high_irq_enable,
   input wire logic i_global_low_irq_enable,
   input wire logic [1:0] i_brownout_config_field,
   input wire logic i_stack_error_reset_enable,
   input wire logic i_portb_analog_default,
   // Avalon-MM slave
   input wire logic [11:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Results toward the core
   output logic [20:0] o_pc,
   output logic o_pc_load,
   output logic o_core_reset,
   output logic o_brownout_armed,
   output logic [7:0] o_high_analog_select,
   output logic o_irq
);
   import rci_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Event priority decode. Only one event class acts per cycle; a
   // lower source pulsing together with a higher one is lost, which
   // matches a real reset swallowing whatever else was pending.
   rci_event_e ev;
   wire logic is_low_pm = (i_pmode == RCI_PM_IDLE) ||
                          (i_pmode == RCI_PM_SLEEP);
   wire logic is_run_pm = (i_pmode == RCI_PM_RUN);
   wire logic gie = i_global_high_irq_enable | i_global_low_irq_enable;
   wire logic sw_bor_mode = (i_brownout_config_field == RCI_BORCFG_SW);

   always_comb
   begin
      if (i_por)
         ev = RCI_EV_POR;
      else if (i_bor)
         ev = RCI_EV_BOR;
      else if (i_external_clear_pin)
         ev = RCI_EV_EXTERNAL_CLEAR_PIN;
      else if (i_wdt)
         ev = RCI_EV_WDT;
      else if (i_reset_insn)
         ev = RCI_EV_RESET_INSN;
      else if (i_stk_full)
         ev = RCI_EV_STK_FULL;
      else if (i_stk_unf)
         ev = RCI_EV_STK_UNF;
      else if (i_irq_wake)
         ev = RCI_EV_IRQ_WAKE;
      else
         ev = RCI_EV_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers
   logic ri_r, to_r, pd_r, por_r, bor_r, software_brownout_enable_r, ful_r, unf_r;
   logic ri_nxt, to_nxt, pd_nxt, por_nxt, bor_nxt, software_brownout_enable_nxt;
   logic ful_nxt, unf_nxt;
   logic [RCI_SP_W-1:0] sp_r, sp_nxt;
   logic [20:0] tos_r, tos_nxt, pc_r, pc_nxt;
   logic pc_load_r, pc_load_nxt, core_rst_r, core_rst_nxt;
   logic [7:0] ansel_r, ansel_nxt, keep_r, keep_nxt;
   logic [RCI_EVT_N-1:0] stat_r, stat_nxt, mask_r;
   logic keep_valid_r;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire logic sel_reset_cause_control = (i_avs_address == RCI_OFS_RESET_CAUSE_CONTROL);
   wire logic sel_stk = (i_avs_address == RCI_OFS_STACK_POINTER_AND_FLAGS);
   wire logic sel_tos = (i_avs_address == RCI_OFS_TOS);
   wire logic sel_pc = (i_avs_address == RCI_OFS_PC);
   wire logic sel_ans = (i_avs_address == RCI_OFS_HIGH_ANALOG_SELECT);
   wire logic sel_keep = (i_avs_address == RCI_OFS_KEEP);
   wire logic sel_stat = (i_avs_address == RCI_OFS_IRQ_STAT);
   wire logic sel_mask = (i_avs_address == RCI_OFS_IRQ_MASK);
   wire logic wr = i_avs_write;
   wire logic [7:0] wd = i_avs_writedata[7:0];
   wire logic [7:0] reset_cause_control_rd = {1'b0, software_brownout_enable_r & sw_bor_mode, 1'b0, ri_r,
                               to_r, pd_r, por_r, bor_r};
   wire logic [7:0] stk_rd = {ful_r, unf_r, 1'b0, sp_r};
   wire logic [31:0] rd_mux =
      sel_reset_cause_control ? {24'h000000, reset_cause_control_rd} :
      sel_stk ? {24'h000000, stk_rd} :
      sel_tos ? {11'h000, tos_r} :
      sel_pc ? {11'h000, pc_r} :
      sel_ans ? {24'h000000, ansel_r} :
      sel_keep ? {24'h000000, keep_r} :
      sel_stat ? {24'h000000, stat_r} :
      sel_mask ? {24'h000000, mask_r} : 32'h00000000;

   // Writes take no wait state. A read waits one cycle, so the
   // registered read data already stand at the edge that ends the read
   // and the master takes them while waitrequest is low.
   // Unmapped reads return zero and unmapped writes are dropped.
   logic rd_wait_done_r;
   wire logic rd_wait_done_nxt = i_avs_read && !rd_wait_done_r;
   assign o_avs_waitrequest = i_avs_read && !rd_wait_done_r;

   ////////////////////////////////////////////////////////////////////////
   // Flag updates per event class
   always_comb
   begin
      // Software writes first, hardware events override them
      ri_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_RI] : ri_r;
      to_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_TO] : to_r;
      pd_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_PD] : pd_r;
      por_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_POR] : por_r;
      bor_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_BOR] : bor_r;
      software_brownout_enable_nxt = (wr && sel_reset_cause_control) ? wd[RCI_B_SOFTWARE_BROWNOUT_ENABLE] : software_brownout_enable_r;
      ful_nxt = (wr && sel_stk) ? wd[RCI_B_STACK_FULL_FLAG] : ful_r;
      unf_nxt = (wr && sel_stk) ? wd[RCI_B_STACK_UNDERFLOW_FLAG] : unf_r;
      sp_nxt = (wr && sel_stk) ? wd[RCI_SP_W-1:0] : sp_r;
      tos_nxt = (wr && sel_tos) ? i_avs_writedata[20:0] : tos_r;
      ansel_nxt = (wr && sel_ans) ? wd : ansel_r;
      keep_nxt = (wr && sel_keep) ? wd : keep_r;
      pc_nxt = pc_r;
      pc_load_nxt = 1'b0;
      core_rst_nxt = 1'b0;
      // Hardware-set reset state classes
      unique case (ev)
         RCI_EV_POR:
         begin
            pc_nxt = RCI_PC_RESET;
            software_brownout_enable_nxt = 1'b1;
            ri_nxt = 1'b1;
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
            por_nxt = 1'b0;
            bor_nxt = 1'b0;
            ful_nxt = 1'b0;
            unf_nxt = 1'b0;
            sp_nxt = '0;
            tos_nxt = '0;
         end
         RCI_EV_BOR:
         begin
            pc_nxt = RCI_PC_RESET;
            ri_nxt = 1'b1;
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
            bor_nxt = 1'b0;
            sp_nxt = '0;
            tos_nxt = '0;
         end
         RCI_EV_EXTERNAL_CLEAR_PIN:
         begin
            pc_nxt = RCI_PC_RESET;
            if (is_run_pm)
               to_nxt = 1'b1;
            if (is_low_pm)
            begin
               to_nxt = 1'b1;
               pd_nxt = 1'b0;
            end
            sp_nxt = '0;
            tos_nxt = '0;
         end
         RCI_EV_WDT:
         begin
            to_nxt = 1'b0;
            if (is_low_pm)
            begin
               pc_nxt = i_pc + RCI_PC_STEP;
               pd_nxt = 1'b0;
            end
            else
            begin
               pc_nxt = RCI_PC_RESET;
               sp_nxt = '0;
               tos_nxt = '0;
            end
         end
         RCI_EV_RESET_INSN:
         begin
            pc_nxt = RCI_PC_RESET;
            ri_nxt = 1'b0;
            sp_nxt = '0;
            tos_nxt = '0;
         end
         RCI_EV_STK_FULL:
         begin
            if (i_stack_error_reset_enable)
            begin
               pc_nxt = RCI_PC_RESET;
               ful_nxt = 1'b1;
               sp_nxt = '0;
               tos_nxt = '0;
            end
         end
         RCI_EV_STK_UNF:
         begin
            unf_nxt = 1'b1;
            if (i_stack_error_reset_enable)
            begin
               pc_nxt = RCI_PC_RESET;
               sp_nxt = '0;
               tos_nxt = '0;
            end
         end
         RCI_EV_IRQ_WAKE:
         begin
            pd_nxt = 1'b0;
            if (gie)
            begin
               pc_nxt = i_irq_high ? RCI_VEC_HIGH : RCI_VEC_LOW;
               tos_nxt = i_pc;
               sp_nxt = sp_r + 1'b1;
            end
            else
               pc_nxt = i_pc + RCI_PC_STEP;
         end
         RCI_EV_NONE:
         begin
         end
      endcase
      // Software brown-out enable kept only in software mode
      if (ev != RCI_EV_POR && ev != RCI_EV_NONE && ev != RCI_EV_IRQ_WAKE
          && !(ev == RCI_EV_WDT && is_low_pm))
         software_brownout_enable_nxt = sw_bor_mode & software_brownout_enable_r;
      // Analog select cleared on every reset class unless i_portb_analog_default is set
      if (ev != RCI_EV_NONE && ev != RCI_EV_IRQ_WAKE
          && !(ev == RCI_EV_WDT && is_low_pm) && !i_portb_analog_default
          && !(ev == RCI_EV_STK_FULL && !i_stack_error_reset_enable)
          && !(ev == RCI_EV_STK_UNF && !i_stack_error_reset_enable))
         ansel_nxt = RCI_HIGH_ANALOG_SELECT_RST;
      if (ev != RCI_EV_NONE && pc_nxt != pc_r)
         pc_load_nxt = 1'b1;
      if (ev != RCI_EV_NONE)
         pc_load_nxt = 1'b1;
      if (ev == RCI_EV_STK_FULL && !i_stack_error_reset_enable)
         pc_load_nxt = 1'b0;
      if (ev == RCI_EV_STK_UNF && !i_stack_error_reset_enable)
         pc_load_nxt = 1'b0;
      // Core held in reset for one cycle on true resets only
      core_rst_nxt = pc_load_nxt && (ev != RCI_EV_IRQ_WAKE) &&
                     !(ev == RCI_EV_WDT && is_low_pm);
   end

   ////////////////////////////////////////////////////////////////////////
   // Event status bits: set wins over write-one-to-clear
   wire logic [RCI_EVT_N-1:0] ev_hit = {
      ev == RCI_EV_IRQ_WAKE, ev == RCI_EV_STK_UNF, ev == RCI_EV_STK_FULL,
      ev == RCI_EV_RESET_INSN, ev == RCI_EV_WDT, ev == RCI_EV_EXTERNAL_CLEAR_PIN,
      ev == RCI_EV_BOR, ev == RCI_EV_POR};
   wire logic [RCI_EVT_N-1:0] stat_clr =
      (wr && sel_stat) ? wd[RCI_EVT_N-1:0] : '0;
   assign stat_nxt = (stat_r & ~stat_clr) | ev_hit;

   // Flags and control registers
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         {ri_r, to_r, pd_r, software_brownout_enable_r} <= 4'hF;
         {por_r, bor_r, ful_r, unf_r} <= 4'h0;
         sp_r <= '0;
         tos_r <= '0;
         pc_r <= RCI_PC_RESET;
         pc_load_r <= 1'b0;
         core_rst_r <= 1'b0;
         ansel_r <= RCI_HIGH_ANALOG_SELECT_RST;
         stat_r <= '0;
         mask_r <= '0;
      end
      else
      begin
         {ri_r, to_r, pd_r, software_brownout_enable_r} <= {ri_nxt, to_nxt, pd_nxt,
                                          software_brownout_enable_nxt};
         {por_r, bor_r, ful_r, unf_r} <= {por_nxt, bor_nxt, ful_nxt,
                                          unf_nxt};
         sp_r <= sp_nxt;
         tos_r <= tos_nxt;
         pc_r <= pc_nxt;
         pc_load_r <= pc_load_nxt;
         core_rst_r <= core_rst_nxt;
         ansel_r <= ansel_nxt;
         stat_r <= stat_nxt;
         if (wr && sel_mask)
            mask_r <= wd;
      end
   end

   // Reset-insensitive register: no async reset, survives all resets.
   // Its contents are meaningless after power-on; the validity bit
   // below masks them on reads until software writes it again.
   always_ff @(posedge i_clk)
   begin
      keep_r <= keep_nxt;
   end

   // Validity of the insensitive register: lost on i_rst and on a power-on event
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         keep_valid_r <= 1'b0;
      else if (ev == RCI_EV_POR)
         keep_valid_r <= 1'b0;
      else if (wr && sel_keep)
         keep_valid_r <= 1'b1;
   end

   // Wait-state tracker: high during the second cycle of each read.
   // Back-to-back reads work because it drops again as each read ends.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rd_wait_done_r <= 1'b0;
      else
         rd_wait_done_r <= rd_wait_done_nxt;
   end

   // Read data register: captured in the first cycle of a read and held
   // through the wait state, so it stands when the read completes.
   // A hardware event in the capture cycle shows in the next read.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_avs_readdata <= 32'h00000000;
      else if (i_avs_read && !rd_wait_done_r)
         o_avs_readdata <= sel_keep && !keep_valid_r ? 32'h00000000 :
                           rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_pc = pc_r;
   assign o_pc_load = pc_load_r;
   assign o_core_reset = core_rst_r;
   assign o_brownout_armed = sw_bor_mode ? software_brownout_enable_r :
                             (i_brownout_config_field != 2'h0);
   assign o_high_analog_select = ansel_r;
   assign o_irq = |(stat_r & mask_r);
endmodule : rci_reset_init

// >>> tb/rci_reset_monitor.sv
`timescale 1ns/100ps
module rci_reset_monitor
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_por,
   input wire logic i_bor,
   input wire logic i_external_clear_pin,
   input wire logic i_wdt,
   input wire logic i_reset_insn,
   input wire logic i_stk_full,
   input wire logic i_stk_unf,
   input wire logic i_irq_wake,
   input wire logic i_irq_high,
   input wire rci_pkg::rci_pmode_e i_pmode,
   input wire logic [20:0] i_pc,
   input wire logic i_global_high_irq_enable,
   input wire logic i_stack_error_reset_enable,
   input wire logic i_portb_analog_default,
   input wire logic [20:0] o_pc,
   input wire logic o_pc_load,
   input wire logic o_core_reset,
   input wire logic [7:0] o_high_analog_select
);
   import rci_pkg::*;
   // Sources that outrank the one under test
   wire ev_hi = i_por | i_bor | i_external_clear_pin;
   wire ev_hw = ev_hi | i_wdt;
   wire ev_hx = ev_hw | i_reset_insn | i_stk_full;
   wire low_pwr = (i_pmode == RCI_PM_IDLE) | (i_pmode == RCI_PM_SLEEP);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////
   a_por_vector: assert property (i_por |=>
      o_pc == RCI_PC_RESET && o_pc_load && o_core_reset)
      else $error("power-on vector wrong");
   a_bor_vector: assert property (i_bor && !i_por |=>
      o_pc == RCI_PC_RESET && o_core_reset) else $error("brownout vector");
   a_clear_vector: assert property (i_external_clear_pin && !i_por && !i_bor |=>
      o_pc == RCI_PC_RESET && o_pc_load) else $error("clear pin vector");
   a_wdt_reset: assert property (i_wdt && !ev_hi && !low_pwr |=>
      o_pc == RCI_PC_RESET && o_core_reset) else $error("watchdog reset");
   a_wdt_resume: assert property (i_wdt && !ev_hi && low_pwr |=>
      o_pc == $past(i_pc) + RCI_PC_STEP && o_pc_load && !o_core_reset)
      else $error("watchdog wake pc");
   a_insn_vector: assert property (i_reset_insn && !ev_hw |=>
      o_pc == RCI_PC_RESET && o_core_reset) else $error("insn reset");
   a_unf_noreset: assert property (i_stk_unf && !ev_hx &&
      !i_stack_error_reset_enable |=> !o_pc_load && !o_core_reset)
      else $error("underflow reset while disabled");
   a_wake_vector: assert property (i_irq_wake && !ev_hx && !i_stk_unf &&
      i_irq_high && i_global_high_irq_enable |=>
      o_pc == RCI_VEC_HIGH && !o_core_reset) else $error("wake vector");
   a_analog_clear: assert property ((i_external_clear_pin || i_reset_insn) &&
      !i_portb_analog_default |=> o_high_analog_select == RCI_HIGH_ANALOG_SELECT_RST)
      else $error("analog select kept");
endmodule : rci_reset_monitor

bind rci_reset_init rci_reset_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
   .i_por(i_por), .i_bor(i_bor), .i_external_clear_pin(i_external_clear_pin), .i_wdt(i_wdt),
   .i_reset_insn(i_reset_insn), .i_stk_full(i_stk_full),
   .i_stk_unf(i_stk_unf), .i_irq_wake(i_irq_wake), .i_irq_high(i_irq_high),
   .i_pmode(i_pmode), .i_pc(i_pc),
   .i_global_high_irq_enable(i_global_high_irq_enable),
   .i_stack_error_reset_enable(i_stack_error_reset_enable),
   .i_portb_analog_default(i_portb_analog_default), .o_pc(o_pc),
   .o_pc_load(o_pc_load), .o_core_reset(o_core_reset),
   .o_high_analog_select(o_high_analog_select));

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import rci_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] ev = 8'h00;
   logic irq_hi = 1'b0;
   rci_pmode_e pmode = RCI_PM_FULL;
   logic [20:0] pc = 21'h000100;
   logic ga_hi = 1'b0;
   logic ga_lo = 1'b0;
   logic [1:0] bcfg = 2'h1;
   logic stv = 1'b1;
   logic pbad = 1'b0;
   logic [11:0] adr = 12'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic wreq, pc_ld, core_rst, armed, irq, irq0;
   logic [20:0] pc_o;
   logic [7:0] ansel;
   logic [31:0] rv;
   int err_total = 0;
   int checked = 0;
   // Free-running clock
   always #5 i_clk = ~i_clk;
   rci_reset_init dut (.i_clk(i_clk), .i_rst(i_rst), .i_por(ev[0]),
      .i_bor(ev[1]), .i_external_clear_pin(ev[2]), .i_wdt(ev[3]), .i_reset_insn(ev[4]),
      .i_stk_full(ev[5]), .i_stk_unf(ev[6]), .i_irq_wake(ev[7]),
      .i_irq_high(irq_hi), .i_pmode(pmode), .i_pc(pc),
      .i_global_high_irq_enable(ga_hi), .i_global_low_irq_enable(ga_lo),
      .i_brownout_config_field(bcfg), .i_stack_error_reset_enable(stv),
      .i_portb_analog_default(pbad), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .o_pc(pc_o), .o_pc_load(pc_ld),
      .o_core_reset(core_rst), .o_brownout_armed(armed),
      .o_high_analog_select(ansel), .o_irq(irq));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic report_and_stop;
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // Compare one value
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : cmp
   // One bus cycle: request held until waitrequest is seen low, read
   // data taken at that same edge, then the request is released
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 50);
      if (!w)
         rv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50)
      begin
         err_total++;
         report_and_stop();
      end
   endtask : bus
   // Read a register and compare
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      cmp(rv, e);
   endtask : rchk
   // Pulse one event and check the core-side results
   task automatic fire(input int b, input rci_pmode_e m,
      input logic [20:0] epc, input logic eld, input logic ers);
      @(posedge i_clk);
      pmode <= m;
      ev[b] <= 1'b1;
      @(posedge i_clk);
      ev <= 8'h00;
      #1;
      if (eld)
         cmp({11'h000, pc_o}, {11'h000, epc});
      cmp({31'h0, pc_ld}, {31'h0, eld});
      cmp({31'h0, core_rst}, {31'h0, ers});
   endtask : fire
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5C);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h00);
      rchk(RCI_OFS_KEEP, 32'h00);
      rchk(12'h800, 32'h00);
      bus(1'b1, RCI_OFS_RESET_CAUSE_CONTROL, 32'h5F);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5F);
      bus(1'b1, RCI_OFS_KEEP, 32'hA5);
      bus(1'b1, RCI_OFS_HIGH_ANALOG_SELECT, 32'h3C);
      fire(4, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h4F);
      cmp({24'h0, ansel}, 32'h00);
      rchk(RCI_OFS_KEEP, 32'hA5);
      fire(1, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5E);
      fire(3, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h56);
      fire(2, RCI_PM_RUN, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5E);
      fire(3, RCI_PM_SLEEP, 21'h000102, 1'b1, 1'b0);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h52);
      rchk(RCI_OFS_KEEP, 32'hA5);
      fire(2, RCI_PM_IDLE, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5A);
      fire(2, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5A);
      fire(5, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h80);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5A);
      fire(6, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'hC0);
      fire(0, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h5C);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h00);
      rchk(RCI_OFS_KEEP, 32'h00);
      stv <= 1'b0;
      fire(6, RCI_PM_FULL, 21'h0, 1'b0, 1'b0);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h40);
      stv <= 1'b1;
      ga_hi <= 1'b1;
      irq_hi <= 1'b1;
      fire(7, RCI_PM_SLEEP, RCI_VEC_HIGH, 1'b1, 1'b0);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h58);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h41);
      rchk(RCI_OFS_TOS, 32'h100);
      ga_hi <= 1'b0;
      ga_lo <= 1'b1;
      irq_hi <= 1'b0;
      pc <= 21'h000200;
      fire(7, RCI_PM_IDLE, RCI_VEC_LOW, 1'b1, 1'b0);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h42);
      rchk(RCI_OFS_TOS, 32'h200);
      ga_lo <= 1'b0;
      fire(7, RCI_PM_SLEEP, 21'h000202, 1'b1, 1'b0);
      rchk(RCI_OFS_STACK_POINTER_AND_FLAGS, 32'h42);
      // Interrupt: clear, raise under both masks, clear again
      bus(1'b1, RCI_OFS_IRQ_STAT, 32'hFF);
      rchk(RCI_OFS_IRQ_STAT, 32'h00);
      bus(1'b1, RCI_OFS_IRQ_MASK, 32'h00);
      fire(3, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      rchk(RCI_OFS_IRQ_STAT, 32'h08);
      irq0 = irq;
      bus(1'b1, RCI_OFS_IRQ_MASK, 32'hFF);
      #1 cmp({31'h0, irq ^ irq0}, 32'h1);
      bus(1'b1, RCI_OFS_IRQ_STAT, 32'h08);
      #1 cmp({31'h0, irq}, 32'h0);
      rchk(RCI_OFS_IRQ_STAT, 32'h00);
      // Analog select kept when default bit set; brownout enable rules
      pbad <= 1'b1;
      bus(1'b1, RCI_OFS_HIGH_ANALOG_SELECT, 32'h3C);
      fire(4, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      cmp({24'h0, ansel}, 32'h3C);
      cmp({31'h0, armed}, 32'h1);
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h40);
      bcfg <= 2'h2;
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h00);
      fire(1, RCI_PM_FULL, 21'h0, 1'b1, 1'b1);
      bcfg <= 2'h1;
      rchk(RCI_OFS_RESET_CAUSE_CONTROL, 32'h1C);
      cmp({31'h0, armed}, 32'h0);
      report_and_stop();
   end
endmodule : tb_top
